// File: core/urs_pkg.sv
// Operation
// [R1] four read/write bytes hold the two resume and two pause characters.
// [R2] power-up sets divisor high byte to 0x00 and low byte to 0x01.
// [R3] the reset input leaves both divisor bytes; only power-up sets them.
// [R4] receive and transmit holding contents are undefined after reset.
// [R5] reset clears interrupt enable, fifo, line and modem control to 0x00.
// [R6] reset sets interrupt identification to 0x01, no interrupt pending.
// [R7] reset sets line status to 0x60, both transmitter empty flags set.
// [R8] reset clears the four low change bits of modem status.
// [R9] after reset the high modem status nibble shows inputs inverted.
// [R10] reset sets the scratchpad to 0xFF.
// [R11] reset sets the enhanced mode select register to 0x80.
// [R12] reset clears fifo level, enhanced feature and fifo count registers.
// [R13] reset clears all four flow control character registers.
// [R14] reset drives transmit, output two, rts and dtr outputs high.
// [R15] reset drives receive-ready high and transmit-ready low.
// [R16] reset leaves the interrupt output undriven.
// [R17] both channels take the same reset state independently.
package urs_pkg;
  localparam int NUM_CH = 2;
  // register offsets, general set
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_INT_EN = 3'h1;
  localparam logic [2:0] OFS_IDENT = 3'h2;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  // offsets with divisor latch access set
  localparam logic [2:0] OFS_DIV_LO = 3'h0;
  localparam logic [2:0] OFS_DIV_HI = 3'h1;
  localparam logic [2:0] OFS_FIFO_LEVEL = 3'h4;
  localparam logic [2:0] OFS_FIFO_COUNT = 3'h5;
  localparam logic [2:0] OFS_ENH_MODE = 3'h7;
  // offsets in the enhanced set
  localparam logic [2:0] OFS_ENH_FEAT = 3'h2;
  localparam logic [2:0] OFS_RESUME1 = 3'h4;
  localparam logic [2:0] OFS_RESUME2 = 3'h5;
  localparam logic [2:0] OFS_PAUSE1 = 3'h6;
  localparam logic [2:0] OFS_PAUSE2 = 3'h7;
  localparam logic [7:0] LINE_CTRL_ENH_KEY = 8'hBF;
  // field positions
  localparam int LINE_DLAB_BIT = 7;
  localparam int LINE_BREAK_BIT = 6;
  localparam int MDM_DTR_BIT = 0;
  localparam int MDM_RTS_BIT = 1;
  localparam int MDM_OUT2_BIT = 3;
  localparam int INTEN_MODEM_BIT = 3;
  localparam int FIFO_ENABLE_BIT = 0;
  localparam int FEAT_ENH_BIT = 4;
  localparam logic [7:0] INTEN_ENH_MASK = 8'hF0;
  localparam logic [7:0] FIFO_ENH_MASK = 8'h30;
  localparam logic [7:0] MDM_ENH_MASK = 8'hE0;
  localparam logic [7:0] FIFO_SELF_CLR_MASK = 8'h06;
  localparam logic [3:0] IDENT_NONE = 4'h1;
  localparam logic [3:0] IDENT_MODEM = 4'h0;
  // reset values
  localparam logic [7:0] DIV_HI_POWER_UP = 8'h00;
  localparam logic [7:0] DIV_LO_POWER_UP = 8'h01;
  localparam logic [7:0] CLEAR_RST = 8'h00;
  localparam logic [7:0] IDENT_RST = 8'h01;
  localparam logic [7:0] LINE_STAT_RST = 8'h60;
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [7:0] ENH_MODE_RST = 8'h80;
  localparam logic [3:0] DELTA_RST = 4'h0;
endpackage : urs_pkg

// File: core/urs_divisor.sv
`timescale 1ns/10ps
// baud divisor bytes, set by host writes and reset only by the power-up reset
module urs_divisor (
  // clock and power-up reset
  input wire logic clk_i,
  input wire logic power_on_n_i,
  // write strobes and data
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wdata_i,
  // divisor bytes
  output logic [7:0] div_lo_o,
  output logic [7:0] div_hi_o
);
  logic [7:0] div_lo_q, div_lo_d;
  logic [7:0] div_hi_q, div_hi_d;

  // next values from host writes
  always_comb begin
    div_lo_d = wr_lo_i ? wdata_i : div_lo_q;
    div_hi_d = wr_hi_i ? wdata_i : div_hi_q;
  end

  // the channel reset is deliberately not wired here
  always_ff @(posedge clk_i or negedge power_on_n_i) begin
    if (!power_on_n_i) begin
      div_lo_q <= urs_pkg::DIV_LO_POWER_UP; // R2
      div_hi_q <= urs_pkg::DIV_HI_POWER_UP; // R2
    end else begin
      div_lo_q <= div_lo_d; // R3
      div_hi_q <= div_hi_d; // R3
    end
  end

  assign div_lo_o = div_lo_q;
  assign div_hi_o = div_hi_q;
endmodule : urs_divisor

// File: core/urs_modem_track.sv
`timescale 1ns/10ps
// modem status: live inverted levels over sticky change bits
module urs_modem_track (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // modem inputs, active low: {cd, ri, dsr, cts}
  input wire logic [3:0] modem_n_i,
  // read of the status clears the change bits
  input wire logic clr_i,
  output logic [7:0] status_o
);
  logic [3:0] level;
  logic [3:0] prev_q, prev_d;
  logic [3:0] delta_q, delta_d;
  logic primed_q, primed_d;
  logic [3:0] event_w;

  assign level = ~modem_n_i;

  // ring indicator flags only its trailing edge
  always_comb begin
    event_w = '0;
    if (primed_q) begin
      event_w[0] = level[0] ^ prev_q[0];
      event_w[1] = level[1] ^ prev_q[1];
      event_w[2] = prev_q[2] & ~level[2];
      event_w[3] = level[3] ^ prev_q[3];
    end
    prev_d = level;
    primed_d = 1'b1;
    // an edge in the clearing cycle survives the clear
    delta_d = (clr_i ? 4'h0 : delta_q) | event_w;
  end

  // first cycle after reset only samples, so no false change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 4'h0;
      primed_q <= 1'b0;
      delta_q <= urs_pkg::DELTA_RST; // R8
    end else begin
      prev_q <= prev_d;
      primed_q <= primed_d;
      delta_q <= delta_d;
    end
  end

  assign status_o = {level, delta_q}; // R9
endmodule : urs_modem_track

// File: core/urs_top.sv
`timescale 1ns/10ps
// register set and pin reset state of a two channel uart
module urs_top (
  // clock and resets
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic POWER_ON_N_I,
  // parallel host bus
  input wire logic [2:0] A_I,
  input wire logic [1:0] CS_N_I,
  input wire logic IOR_N_I,
  input wire logic IOW_N_I,
  input wire logic [7:0] D_I,
  output logic [7:0] D_O,
  output logic D_OE_O,
  // modem inputs per channel
  input wire logic [1:0] CTS_N_I,
  input wire logic [1:0] DSR_N_I,
  input wire logic [1:0] RI_N_I,
  input wire logic [1:0] CD_N_I,
  // serial and modem outputs per channel
  output logic [1:0] TX_O,
  output logic [1:0] GP_OUT2_N_O,
  output logic [1:0] RTS_N_O,
  output logic [1:0] DTR_N_O,
  // ready and interrupt outputs per channel
  output logic [1:0] RX_READY_N_O,
  output logic [1:0] TX_READY_N_O,
  output logic [1:0] INT_O,
  output logic [1:0] INT_OE_O
);
  localparam int NCH = urs_pkg::NUM_CH;

  logic ior_q, ior_d;
  logic iow_q, iow_d;
  logic rd_stb, wr_stb;
  logic [7:0] d_out_q, d_out_d;
  logic d_oe_q, d_oe_d;
  logic [7:0] rdata_ch [NCH];

  // strobes act once, on their falling edge
  assign rd_stb = ior_q & ~IOR_N_I;
  assign wr_stb = iow_q & ~IOW_N_I;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      logic wr, rd, dlab, enh, allow_enh;
      logic [7:0] int_enable_q, int_enable_d;
      logic [7:0] fifo_ctrl_q, fifo_ctrl_d;
      logic [7:0] line_ctrl_q, line_ctrl_d;
      logic [7:0] modem_ctrl_q, modem_ctrl_d;
      logic [7:0] scratch_q, scratch_d;
      logic [7:0] enh_mode_q, enh_mode_d;
      logic [7:0] enh_feat_q, enh_feat_d;
      logic [7:0] resume1_q, resume1_d;
      logic [7:0] resume2_q, resume2_d;
      logic [7:0] pause1_q, pause1_d;
      logic [7:0] pause2_q, pause2_d;
      logic [7:0] tx_hold_q, tx_hold_d;
      logic [7:0] line_stat;
      logic [7:0] int_ident;
      logic [7:0] modem_stat;
      logic [7:0] fifo_level;
      logic [7:0] fifo_count;
      logic [7:0] div_lo, div_hi;
      logic wr_div_lo, wr_div_hi, clr_modem;
      logic modem_pend;

      assign wr = wr_stb & ~CS_N_I[g];
      assign rd = rd_stb & ~CS_N_I[g];
      assign dlab = line_ctrl_q[urs_pkg::LINE_DLAB_BIT];
      assign enh = (line_ctrl_q == urs_pkg::LINE_CTRL_ENH_KEY);
      assign allow_enh = enh_feat_q[urs_pkg::FEAT_ENH_BIT];

      // no transmitter or receiver here, so status stays idle
      assign line_stat = urs_pkg::LINE_STAT_RST; // R7
      assign fifo_level = urs_pkg::CLEAR_RST; // R12
      assign fifo_count = urs_pkg::CLEAR_RST; // R12

      // modem change is the only interrupt source in this block
      assign modem_pend = int_enable_q[urs_pkg::INTEN_MODEM_BIT]
                          & (|modem_stat[3:0]);
      always_comb begin
        int_ident = urs_pkg::IDENT_RST; // R6
        int_ident[7:6] = {2{fifo_ctrl_q[urs_pkg::FIFO_ENABLE_BIT]}};
        int_ident[3:0] = modem_pend ? urs_pkg::IDENT_MODEM
                                    : urs_pkg::IDENT_NONE;
      end

      // divisor writes go to the power-up only store
      assign wr_div_lo = wr & dlab & (A_I == urs_pkg::OFS_DIV_LO);
      assign wr_div_hi = wr & dlab & (A_I == urs_pkg::OFS_DIV_HI);
      assign clr_modem = rd & ~enh & (A_I == urs_pkg::OFS_MODEM_STAT);

      urs_divisor u_div (
        .clk_i(CLK_I),
        .power_on_n_i(POWER_ON_N_I),
        .wr_lo_i(wr_div_lo),
        .wr_hi_i(wr_div_hi),
        .wdata_i(D_I),
        .div_lo_o(div_lo),
        .div_hi_o(div_hi)
      );

      urs_modem_track u_modem (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .modem_n_i({CD_N_I[g], RI_N_I[g], DSR_N_I[g], CTS_N_I[g]}),
        .clr_i(clr_modem),
        .status_o(modem_stat)
      );

      // host writes; enhanced bits only change while unlocked
      always_comb begin
        int_enable_d = int_enable_q;
        fifo_ctrl_d = fifo_ctrl_q & ~urs_pkg::FIFO_SELF_CLR_MASK;
        line_ctrl_d = line_ctrl_q;
        modem_ctrl_d = modem_ctrl_q;
        scratch_d = scratch_q;
        enh_mode_d = enh_mode_q;
        enh_feat_d = enh_feat_q;
        resume1_d = resume1_q;
        resume2_d = resume2_q;
        pause1_d = pause1_q;
        pause2_d = pause2_q;
        tx_hold_d = tx_hold_q;
        if (wr) begin
          unique case (A_I)
            urs_pkg::OFS_HOLD: begin
              if (!dlab) begin
                tx_hold_d = D_I;
              end
            end
            urs_pkg::OFS_INT_EN: begin
              if (!dlab) begin
                int_enable_d = allow_enh ? D_I
                  : (D_I & ~urs_pkg::INTEN_ENH_MASK)
                  | (int_enable_q & urs_pkg::INTEN_ENH_MASK);
              end
            end
            urs_pkg::OFS_IDENT: begin
              if (enh) begin
                enh_feat_d = D_I;
              end else if (!dlab) begin
                fifo_ctrl_d = (allow_enh ? D_I
                  : (D_I & ~urs_pkg::FIFO_ENH_MASK)
                  | (fifo_ctrl_q & urs_pkg::FIFO_ENH_MASK))
                  & ~urs_pkg::FIFO_SELF_CLR_MASK;
              end
            end
            urs_pkg::OFS_LINE_CTRL: begin
              line_ctrl_d = D_I;
            end
            urs_pkg::OFS_MODEM_CTRL: begin
              if (enh) begin
                resume1_d = D_I; // R1
              end else if (!dlab) begin
                modem_ctrl_d = allow_enh ? D_I
                  : (D_I & ~urs_pkg::MDM_ENH_MASK)
                  | (modem_ctrl_q & urs_pkg::MDM_ENH_MASK);
              end
            end
            urs_pkg::OFS_LINE_STAT: begin
              if (enh) begin
                resume2_d = D_I; // R1
              end
            end
            urs_pkg::OFS_MODEM_STAT: begin
              if (enh) begin
                pause1_d = D_I; // R1
              end
            end
            urs_pkg::OFS_SCRATCH: begin
              if (enh) begin
                pause2_d = D_I; // R1
              end else if (dlab) begin
                enh_mode_d = D_I;
              end else begin
                scratch_d = D_I;
              end
            end
          endcase
        end
      end

      // reset state; holding data is left without reset on purpose
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          int_enable_q <= urs_pkg::CLEAR_RST; // R5
          fifo_ctrl_q <= urs_pkg::CLEAR_RST; // R5
          line_ctrl_q <= urs_pkg::CLEAR_RST; // R5
          modem_ctrl_q <= urs_pkg::CLEAR_RST; // R5
          scratch_q <= urs_pkg::SCRATCH_RST; // R10
          enh_mode_q <= urs_pkg::ENH_MODE_RST; // R11
          enh_feat_q <= urs_pkg::CLEAR_RST; // R12
          resume1_q <= urs_pkg::CLEAR_RST; // R13
          resume2_q <= urs_pkg::CLEAR_RST; // R13
          pause1_q <= urs_pkg::CLEAR_RST; // R13
          pause2_q <= urs_pkg::CLEAR_RST; // R13
        end else begin
          int_enable_q <= int_enable_d;
          fifo_ctrl_q <= fifo_ctrl_d;
          line_ctrl_q <= line_ctrl_d;
          modem_ctrl_q <= modem_ctrl_d;
          scratch_q <= scratch_d;
          enh_mode_q <= enh_mode_d;
          enh_feat_q <= enh_feat_d;
          resume1_q <= resume1_d;
          resume2_q <= resume2_d;
          pause1_q <= pause1_d;
          pause2_q <= pause2_d;
        end
      end

      // holding data carries no defined reset value
      always_ff @(posedge CLK_I) begin
        tx_hold_q <= tx_hold_d; // R4
      end

      // read mux; receive holding reads back the last written byte
      always_comb begin
        rdata_ch[g] = urs_pkg::CLEAR_RST;
        unique case (A_I)
          urs_pkg::OFS_HOLD: begin
            rdata_ch[g] = dlab ? div_lo : tx_hold_q; // R4
          end
          urs_pkg::OFS_INT_EN: begin
            rdata_ch[g] = dlab ? div_hi : int_enable_q;
          end
          urs_pkg::OFS_IDENT: begin
            rdata_ch[g] = enh ? enh_feat_q : int_ident;
          end
          urs_pkg::OFS_LINE_CTRL: begin
            rdata_ch[g] = line_ctrl_q;
          end
          urs_pkg::OFS_MODEM_CTRL: begin
            rdata_ch[g] = enh ? resume1_q
                        : (dlab ? fifo_level : modem_ctrl_q);
          end
          urs_pkg::OFS_LINE_STAT: begin
            rdata_ch[g] = enh ? resume2_q
                        : (dlab ? fifo_count : line_stat);
          end
          urs_pkg::OFS_MODEM_STAT: begin
            rdata_ch[g] = enh ? pause1_q : modem_stat;
          end
          urs_pkg::OFS_SCRATCH: begin
            rdata_ch[g] = enh ? pause2_q
                        : (dlab ? enh_mode_q : scratch_q);
          end
        endcase
      end

      // pins follow reset-cleared modem and line control
      assign TX_O[g] = ~line_ctrl_q[urs_pkg::LINE_BREAK_BIT]; // R14
      assign GP_OUT2_N_O[g] = ~modem_ctrl_q[urs_pkg::MDM_OUT2_BIT]; // R14
      assign RTS_N_O[g] = ~modem_ctrl_q[urs_pkg::MDM_RTS_BIT]; // R14
      assign DTR_N_O[g] = ~modem_ctrl_q[urs_pkg::MDM_DTR_BIT]; // R14
      // no receive data and no transmit backlog in this block
      assign RX_READY_N_O[g] = 1'b1; // R15
      assign TX_READY_N_O[g] = 1'b0; // R15
      // interrupt pin is driven only while output two is enabled
      assign INT_OE_O[g] = modem_ctrl_q[urs_pkg::MDM_OUT2_BIT]; // R16
      assign INT_O[g] = ~int_ident[0];
    end
  endgenerate

  // strobe history and registered read data, shared by channels
  always_comb begin
    ior_d = IOR_N_I;
    iow_d = IOW_N_I;
    d_oe_d = ~IOR_N_I & ~(&CS_N_I);
    d_out_d = d_out_q;
    if (rd_stb) begin
      // channel a wins if both selects are low
      d_out_d = !CS_N_I[0] ? rdata_ch[0] : rdata_ch[1]; // R17
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ior_q <= 1'b1;
      iow_q <= 1'b1;
      d_oe_q <= 1'b0;
      d_out_q <= urs_pkg::CLEAR_RST;
    end else begin
      ior_q <= ior_d;
      iow_q <= iow_d;
      d_oe_q <= d_oe_d;
      d_out_q <= d_out_d;
    end
  end

  assign D_O = d_out_q;
  assign D_OE_O = d_oe_q;
endmodule : urs_top

// File: bench/urs_top_monitor.sv
`timescale 1ns/10ps
// reset pin checks on both channels, read-back checks on channel a
module urs_top_monitor (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // host bus
  input wire logic [2:0] A_I,
  input wire logic [1:0] CS_N_I,
  input wire logic IOR_N_I,
  input wire logic IOW_N_I,
  input wire logic [7:0] D_I,
  input wire logic [7:0] D_O,
  input wire logic D_OE_O,
  // modem inputs
  input wire logic [1:0] CTS_N_I,
  input wire logic [1:0] DSR_N_I,
  input wire logic [1:0] RI_N_I,
  input wire logic [1:0] CD_N_I,
  // pins
  input wire logic [1:0] TX_O,
  input wire logic [1:0] GP_OUT2_N_O,
  input wire logic [1:0] RTS_N_O,
  input wire logic [1:0] DTR_N_O,
  input wire logic [1:0] RX_READY_N_O,
  input wire logic [1:0] TX_READY_N_O,
  input wire logic [1:0] INT_O,
  input wire logic [1:0] INT_OE_O
);
  logic ior_q, ior_d, iow_q, iow_d, rd_take, wr_take;
  logic [7:0] lctl_q, lctl_d;
  // a strobe counts only on its first low edge
  assign rd_take = ior_q && !IOR_N_I && !CS_N_I[0];
  assign wr_take = iow_q && !IOW_N_I && !CS_N_I[0];
  // shadow of line control, needed to decode reads
  always_comb begin
    ior_d = IOR_N_I;
    iow_d = IOW_N_I;
    lctl_d = lctl_q;
    if (wr_take && A_I == urs_pkg::OFS_LINE_CTRL) begin
      lctl_d = D_I;
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ior_q <= 1'b1;
      iow_q <= 1'b1;
      lctl_q <= 8'h00;
    end else begin
      ior_q <= ior_d;
      iow_q <= iow_d;
      lctl_q <= lctl_d;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_rel_tx_high: assert property ($rose(RST_N_I) |-> TX_O == 2'b11)
    else $error("serial out not high at reset release");
  a_rel_pins_high: assert property (
    $rose(RST_N_I) |-> &{RTS_N_O, DTR_N_O, GP_OUT2_N_O})
    else $error("modem outputs not high at reset release");
  a_ready_fixed: assert property (
    RX_READY_N_O == 2'b11 && TX_READY_N_O == 2'b00)
    else $error("ready outputs wrong");
  a_rel_int_off: assert property ($rose(RST_N_I) |-> !INT_OE_O)
    else $error("interrupt pin driven at reset release");
  a_int_oe_out2: assert property (INT_OE_O == ~GP_OUT2_N_O)
    else $error("interrupt enable apart from output two");
  a_lsr_value: assert property (
    rd_take && A_I == urs_pkg::OFS_LINE_STAT && !lctl_q[7]
    |-> ##2 D_O == 8'h60)
    else $error("line status read wrong");
  a_msr_levels: assert property (
    rd_take && A_I == urs_pkg::OFS_MODEM_STAT && lctl_q != 8'hBF
    |-> ##2 D_O[7:4] == ~{CD_N_I[0], RI_N_I[0], DSR_N_I[0], CTS_N_I[0]})
    else $error("modem status levels wrong");
  a_ident_none: assert property (
    rd_take && A_I == urs_pkg::OFS_IDENT && lctl_q != 8'hBF && !INT_O[0]
    |-> ##2 D_O[3:0] == 4'h1)
    else $error("ident not idle");
  // data enable follows a read one cycle late, off while idle
  a_read_oe_on: assert property (rd_take |=> D_OE_O)
    else $error("data enable missing after read");
  a_idle_oe_off: assert property (IOR_N_I |=> !D_OE_O)
    else $error("data enable set without read");
endmodule : urs_top_monitor

bind urs_top urs_top_monitor u_urs_top_monitor (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .A_I(A_I), .CS_N_I(CS_N_I), .IOR_N_I(IOR_N_I),
  .IOW_N_I(IOW_N_I), .D_I(D_I), .D_O(D_O), .D_OE_O(D_OE_O),
  .CTS_N_I(CTS_N_I),
  .DSR_N_I(DSR_N_I), .RI_N_I(RI_N_I), .CD_N_I(CD_N_I), .TX_O(TX_O),
  .GP_OUT2_N_O(GP_OUT2_N_O), .RTS_N_O(RTS_N_O), .DTR_N_O(DTR_N_O),
  .RX_READY_N_O(RX_READY_N_O), .TX_READY_N_O(TX_READY_N_O),
  .INT_O(INT_O), .INT_OE_O(INT_OE_O));

// File: bench/urs_host.sv
`timescale 1ns/10ps
// host processor on the parallel register bus
module urs_host (
  // bus clock
  input wire logic clk_i,
  // address, selects and strobes
  output logic [2:0] a_o,
  output logic [1:0] cs_n_o,
  output logic ior_n_o,
  output logic iow_n_o,
  // data both ways
  output logic [7:0] d_o,
  input wire logic [7:0] d_i
);
  // idle bus from time zero
  initial begin
    a_o = 3'h0;
    cs_n_o = 2'b11;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    d_o = 8'h00;
  end
  // write is taken on the first low edge; released lines flip
  task automatic write_reg(input int ch, input logic [2:0] a,
                           input logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= ~(2'b01 << ch);
    a_o <= a;
    d_o <= d;
    iow_n_o <= 1'b0;
    @(posedge clk_i);
    iow_n_o <= 1'b1;
    cs_n_o <= 2'b11;
    a_o <= ~a;
    d_o <= ~d;
  endtask : write_reg
  // read holds the strobe one extra edge so data has settled
  task automatic read_reg(input int ch, input logic [2:0] a,
                          output logic [7:0] q);
    @(posedge clk_i);
    cs_n_o <= ~(2'b01 << ch);
    a_o <= a;
    ior_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    ior_n_o <= 1'b1;
    cs_n_o <= 2'b11;
    a_o <= ~a;
    #1;
    q = d_i;
  endtask : read_reg
endmodule : urs_host

// File: bench/uart_channel_reset_state_test.sv
`timescale 1ns/10ps
// reset state of both channels through the host bus
module uart_channel_reset_state_test;
  logic clk, rst_n, pon_n, ior_n, iow_n, d_oe;
  logic [2:0] a;
  logic [1:0] cs_n, tx, out2_n, rts_n, dtr_n, rxr_n, txr_n, irq, irq_oe;
  logic [7:0] d_wr, d_rd;
  // modem inputs steady apart from one change on channel a
  logic [1:0] cts_n = 2'b01;
  logic [1:0] dsr_n = 2'b10;
  logic [1:0] ri_n = 2'b11;
  logic [1:0] cd_n = 2'b00;
  int n_mismatch = 0;
  int num_checks = 0;

  urs_top u_urs_top (.CLK_I(clk), .RST_N_I(rst_n), .POWER_ON_N_I(pon_n),
    .A_I(a), .CS_N_I(cs_n), .IOR_N_I(ior_n), .IOW_N_I(iow_n), .D_I(d_wr),
    .D_O(d_rd), .D_OE_O(d_oe), .CTS_N_I(cts_n), .DSR_N_I(dsr_n),
    .RI_N_I(ri_n), .CD_N_I(cd_n), .TX_O(tx), .GP_OUT2_N_O(out2_n),
    .RTS_N_O(rts_n), .DTR_N_O(dtr_n), .RX_READY_N_O(rxr_n),
    .TX_READY_N_O(txr_n), .INT_O(irq), .INT_OE_O(irq_oe));
  urs_host u_urs_host (.clk_i(clk), .a_o(a), .cs_n_o(cs_n),
    .ior_n_o(ior_n), .iow_n_o(iow_n), .d_o(d_wr), .d_i(d_rd));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic chk(input int ch, input logic [2:0] a_r,
                     input logic [7:0] e, input string nm);
    logic [7:0] q;
    u_urs_host.read_reg(ch, a_r, q);
    cmp(nm, e, q);
  endtask : chk

  // pin levels held by reset, both channels
  task automatic pins_reset();
    cmp("tx", 8'h03, {6'h00, tx});
    cmp("out2_n", 8'h03, {6'h00, out2_n});
    cmp("rts_n", 8'h03, {6'h00, rts_n});
    cmp("dtr_n", 8'h03, {6'h00, dtr_n});
    cmp("rx_ready_n", 8'h03, {6'h00, rxr_n});
    cmp("tx_ready_n", 8'h00, {6'h00, txr_n});
    cmp("int_oe", 8'h00, {6'h00, irq_oe});
  endtask : pins_reset

  // every readable register of one channel but holding and line control against its reset value
  task automatic check_reset(input int ch, input logic [15:0] div);
    logic [7:0] mstat;
    mstat = {~cd_n[ch], ~ri_n[ch], ~dsr_n[ch], ~cts_n[ch], 4'h0};
    u_urs_host.write_reg(ch, urs_pkg::OFS_LINE_CTRL, 8'h00);
    chk(ch, urs_pkg::OFS_INT_EN, 8'h00, "int_enable");
    chk(ch, urs_pkg::OFS_IDENT, 8'h01, "ident");
    chk(ch, urs_pkg::OFS_MODEM_CTRL, 8'h00, "modem_ctrl");
    chk(ch, urs_pkg::OFS_LINE_STAT, 8'h60, "line_stat");
    chk(ch, urs_pkg::OFS_MODEM_STAT, mstat, "modem_stat");
    chk(ch, urs_pkg::OFS_SCRATCH, 8'hFF, "scratch");
    u_urs_host.write_reg(ch, urs_pkg::OFS_LINE_CTRL, 8'h80);
    chk(ch, urs_pkg::OFS_DIV_LO, div[7:0], "div_lo");
    chk(ch, urs_pkg::OFS_DIV_HI, div[15:8], "div_hi");
    chk(ch, urs_pkg::OFS_FIFO_LEVEL, 8'h00, "fifo_level");
    chk(ch, urs_pkg::OFS_FIFO_COUNT, 8'h00, "fifo_count");
    chk(ch, urs_pkg::OFS_ENH_MODE, 8'h80, "enh_mode");
    u_urs_host.write_reg(ch, urs_pkg::OFS_LINE_CTRL, 8'hBF);
    chk(ch, urs_pkg::OFS_LINE_CTRL, 8'hBF, "line_ctrl");
    chk(ch, urs_pkg::OFS_ENH_FEAT, 8'h00, "enh_feat");
    for (int i = 4; i < 8; i++) begin
      chk(ch, 3'(i), 8'h00, "flow_char");
    end
  endtask : check_reset

  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    pon_n = 1'b0;
    repeat (6) @(posedge clk);
    pins_reset();
    rst_n <= 1'b1;
    pon_n <= 1'b1;
    @(posedge clk);
    #1;
    pins_reset();
    check_reset(0, 16'h0001);
    check_reset(1, 16'h0001);
    // program channel a away from reset in every field but enhanced feature and enhanced mode select
    for (int i = 4; i < 8; i++) begin
      u_urs_host.write_reg(0, 3'(i), 8'h10 + 8'(i));
    end
    for (int i = 4; i < 8; i++) begin
      chk(0, 3'(i), 8'h10 + 8'(i), "flow_char_rw");
    end
    u_urs_host.write_reg(0, urs_pkg::OFS_DIV_LO, 8'h34);
    u_urs_host.write_reg(0, urs_pkg::OFS_DIV_HI, 8'h12);
    u_urs_host.write_reg(0, urs_pkg::OFS_LINE_CTRL, 8'h00);
    u_urs_host.write_reg(0, urs_pkg::OFS_INT_EN, 8'h0F);
    u_urs_host.write_reg(0, urs_pkg::OFS_IDENT, 8'h01);
    u_urs_host.write_reg(0, urs_pkg::OFS_MODEM_CTRL, 8'h0B);
    u_urs_host.write_reg(0, urs_pkg::OFS_SCRATCH, 8'h5A);
    u_urs_host.write_reg(0, urs_pkg::OFS_LINE_CTRL, 8'h40);
    chk(0, urs_pkg::OFS_SCRATCH, 8'h5A, "scratch_rw");
    cmp("tx_break", 8'h02, {6'h00, tx});
    cmp("rts_n_set", 8'h02, {6'h00, rts_n});
    cmp("int_oe_set", 8'h01, {6'h00, irq_oe});
    check_reset(1, 16'h0001);
    // a pending change bit on channel a, so the reset below must clear it
    @(posedge clk);
    cts_n[0] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp("int_pend", 8'h01, {6'h00, irq});
    // reset pin alone: divisor of channel a must survive
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    pins_reset();
    rst_n <= 1'b1;
    check_reset(0, 16'h1234);
    check_reset(1, 16'h0001);
    complete_run();
  end
endmodule : uart_channel_reset_state_test
